// ---- design/qpdbi_drive_end.sv ----
/*
 * Driving agent of the quad-pumped data phase: takes one 256-bit beat per
 * common clock and places it on the bus as four 64-bit sub-phases.
 * Assumes the receiver samples with its own clock, and that the interface
 * resolves released lines to the pull-up level.
 */
`timescale 1ns/100ps
`default_nettype none

module qpdbi_drive_end
    import qpdbi_pkg::*;
(
    input  wire logic              clk_sys,  // System clock, 100 MHz.
    input  wire logic              rst,      // Asynchronous reset, active high.
    input  wire logic              tx_valid, // A beat is offered.
    input  wire logic [BEAT_W-1:0] tx_data,  // Beat, sub-phase 0 in low word.
    input  wire logic              inv_en,   // Allow bus inversion.
    output logic                   tx_ready, // Beat taken in this cycle if tx_valid is high.
    qpdbi_if.drive_mp              bus       // Shared bus lines.
);

    // ------------------------------------------------------------------
    // Inversion decision
    // ------------------------------------------------------------------
    // Returns one bit per group, set where the group will be sent inverted.
    // A logical one is driven low, so the ones of a group are its low lines.
    function automatic logic [GROUPS-1:0] inv_pick(input logic [DATA_W-1:0] w,
                                                   input logic en);
        logic [GROUPS-1:0] r;
        int                c;
        r = '0;
        for (int g = 0; g < GROUPS; g++) begin
            c = 0;
            for (int b = 0; b < GROUP_W; b++) begin
                c = c + int'(w[g*GROUP_W+b]);
            end
            r[g] = en && (c > HALF_GROUP);
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [1:0]        cyc_q, cyc_d;       // Cycle within a sub-phase.
    logic [1:0]        sub_q, sub_d;       // Sub-phase within the clock.
    logic              ready_q, ready_d;   // Beat acceptance window.
    logic              active_q, active_d; // Current common clock carries data.
    logic [BEAT_W-1:0] beat_q, beat_d;     // Beat being sent.
    logic [DATA_W-1:0] data_q, data_d;     // Electrical data levels.
    logic [GROUPS-1:0] flag_q, flag_d;     // Electrical flag levels.
    logic              valid_q, valid_d;   // Electrical valid level.
    logic              doe_q, doe_d;       // Data lines driven.
    logic [GROUPS-1:0] stbp_q, stbp_d;     // Positive strobe levels.
    logic [GROUPS-1:0] stbn_q, stbn_d;     // Negative strobe levels.
    logic              soe_q, soe_d;       // Strobes driven.

    logic              end_phase;          // Last cycle of a sub-phase.
    logic              boundary;           // Last cycle of a common clock.
    logic              take;               // Beat accepted now.
    logic [BEAT_W-1:0] src;                // Beat feeding the next sub-phase.
    logic [DATA_W-1:0] word;               // Word of the next sub-phase.
    logic [GROUPS-1:0] inv;                // Groups inverted next sub-phase.

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // The common clock is made here by dividing clk_sys; the bus never
    // stops, idle clocks simply leave the lines released.
    always_comb begin
        end_phase = (cyc_q == CYC_LAST);
        boundary  = end_phase && (sub_q == SUB_LAST);
        take      = boundary && ready_q && tx_valid;
        cyc_d     = end_phase ? 2'h0 : cyc_q + 2'h1;
        sub_d     = end_phase ? sub_q + 2'h1 : sub_q;
        ready_d   = (cyc_q == CYC_LAST - 2'h1) && (sub_q == SUB_LAST);
        // An empty offer at the boundary yields an idle clock.
        active_d  = boundary ? take : active_q;
        beat_d    = take ? tx_data : beat_q;
        src       = boundary ? tx_data : beat_q;
        word      = src[sub_d*DATA_W +: DATA_W];
        inv       = inv_pick(word, inv_en);
        data_d    = data_q;
        flag_d    = flag_q;
        valid_d   = valid_q;
        doe_d     = doe_q;
        stbp_d    = stbp_q;
        stbn_d    = stbn_q;
        soe_d     = soe_q;
        if (end_phase) begin
            // New sub-phase: data, flags and valid change together.
            for (int g = 0; g < GROUPS; g++) begin
                // Logical one drives low; flagged groups go out uninverted
                // electrically, which is the inverted code.
                data_d[g*GROUP_W +: GROUP_W] = ~word[g*GROUP_W +: GROUP_W]
                                               ^ {GROUP_W{inv[g]}};
            end
            flag_d  = ~inv;
            valid_d = ~active_d;
            doe_d   = active_d;
            if (!active_d) begin
                data_d = DATA_IDLE;
                flag_d = GRP_IDLE;
            end
        end
        if (cyc_q == CYC_STB) begin
            // Mid sub-phase: even sub-phases fall on the positive strobe,
            // odd ones on the negative, with data already stable.
            stbp_d = active_q ? {GROUPS{sub_q[0]}} : GRP_IDLE;
            stbn_d = active_q ? {GROUPS{~sub_q[0]}} : GRP_IDLE;
            soe_d  = active_q;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cyc_q    <= 2'h0;
            sub_q    <= 2'h0;
            ready_q  <= 1'b0;
            active_q <= 1'b0;
            beat_q   <= '0;
            data_q   <= DATA_IDLE;
            flag_q   <= GRP_IDLE;
            valid_q  <= 1'b1;
            doe_q    <= 1'b0;
            stbp_q   <= GRP_IDLE;
            stbn_q   <= GRP_IDLE;
            soe_q    <= 1'b0;
        end else begin
            cyc_q    <= cyc_d;
            sub_q    <= sub_d;
            ready_q  <= ready_d;
            active_q <= active_d;
            beat_q   <= beat_d;
            data_q   <= data_d;
            flag_q   <= flag_d;
            valid_q  <= valid_d;
            doe_q    <= doe_d;
            stbp_q   <= stbp_d;
            stbn_q   <= stbn_d;
            soe_q    <= soe_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every line comes straight from a flip-flop, so no glitch reaches the pins.
    assign tx_ready      = ready_q;
    assign bus.data_drv  = data_q;
    assign bus.data_oe   = doe_q;
    assign bus.flag_drv  = flag_q;
    assign bus.valid_drv = valid_q;
    assign bus.stbp_drv  = stbp_q;
    assign bus.stbn_drv  = stbn_q;
    assign bus.stb_oe    = soe_q;

endmodule

`default_nettype wire

// ---- design/qpdbi_pkg.sv ----
/*
 * Shared constants for the quad-pumped data phase with per-group bus inversion.
 * Assumes both ends run on a 100 MHz clk_sys and import this package whole.
 */
package qpdbi_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int DATA_W     = 64;               // Data lines on the bus.
    localparam int GROUP_W    = 16;               // Lines per strobe group.
    localparam int GROUPS     = DATA_W / GROUP_W; // Strobe pairs and flags.
    localparam int SUBPHASES  = 4;                // Transfers per common clock.
    localparam int BEAT_W     = DATA_W * SUBPHASES; // One common clock of data.
    localparam int HALF_GROUP = GROUP_W / 2;      // Inversion threshold.

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS      = 10;  // clk_sys period.
    localparam int SUBPHASE_NS = 40;  // One sub-phase, a quarter of 160 ns.
    localparam int SUB_CYC     = (SUBPHASE_NS + CLK_NS - 1) / CLK_NS;

    // Cycle of a sub-phase that ends it, and the cycle before the strobe edge.
    localparam logic [1:0] CYC_LAST = 2'(SUB_CYC - 1);
    localparam logic [1:0] CYC_STB  = 2'h1;
    localparam logic [1:0] SUB_LAST = 2'(SUBPHASES - 1);

    // Idle level of every active-low line.
    localparam logic [DATA_W-1:0] DATA_IDLE = {DATA_W{1'b1}};
    localparam logic [GROUPS-1:0] GRP_IDLE  = {GROUPS{1'b1}};

endpackage

// ---- design/qpdbi_if.sv ----
/*
 * Wires of the shared data phase between the driving and receiving agent.
 * Assumes an undriven line is pulled up, so it reads deasserted (high).
 */
`timescale 1ns/100ps
`default_nettype none

interface qpdbi_if;
    import qpdbi_pkg::*;

    // ------------------------------------------------------------------
    // Driver side: values and enables
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] data_drv;   // Data value driven.
    logic              data_oe;    // Data, flags and valid are driven.
    logic [GROUPS-1:0] flag_drv;   // Inversion flags driven.
    logic              valid_drv;  // Valid line driven.
    logic [GROUPS-1:0] stbp_drv;   // Positive strobes driven.
    logic [GROUPS-1:0] stbn_drv;   // Negative strobes driven.
    logic              stb_oe;     // Strobes are driven.

    // ------------------------------------------------------------------
    // Resolved wire levels
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] bus_data_n;          // Data lines.
    logic [GROUPS-1:0] group_invert_flag_n; // Inversion flags.
    logic              transfer_valid_n;    // Valid transfer marker.
    logic [GROUPS-1:0] group_strobe_pos_n;  // Positive strobes.
    logic [GROUPS-1:0] group_strobe_neg_n;  // Negative strobes.

    // Released lines float to the pull-up level.
    assign bus_data_n          = data_oe ? data_drv : DATA_IDLE;
    assign group_invert_flag_n = data_oe ? flag_drv : GRP_IDLE;
    assign transfer_valid_n    = data_oe ? valid_drv : 1'b1;
    assign group_strobe_pos_n  = stb_oe ? stbp_drv : GRP_IDLE;
    assign group_strobe_neg_n  = stb_oe ? stbn_drv : GRP_IDLE;

    modport drive_mp (
        output data_drv, data_oe, flag_drv, valid_drv, stbp_drv, stbn_drv, stb_oe
    );

    modport receive_mp (
        input bus_data_n, group_invert_flag_n, transfer_valid_n,
        input group_strobe_pos_n, group_strobe_neg_n
    );

endinterface

`default_nettype wire

// ---- design/qpdbi_recv_end.sv ----
/*
 * Receiving agent of the quad-pumped data phase: samples all lines with
 * clk_sys, finds strobe falling edges per group and rebuilds each beat.
 * Assumes sub-phases of at least four clk_sys cycles with the strobe edge
 * near the middle, so synchronised data is stable at the detected edge.
 */
`timescale 1ns/100ps
`default_nettype none

module qpdbi_recv_end
    import qpdbi_pkg::*;
(
    input  wire logic        clk_sys,  // System clock, 100 MHz.
    input  wire logic        rst,      // Asynchronous reset, active high.
    qpdbi_if.receive_mp      bus,      // Shared bus lines.
    output logic             rx_valid, // One-cycle pulse, beat complete.
    output logic [BEAT_W-1:0] rx_data  // Beat, sub-phase 0 in low word.
);

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    // Data and strobes take the same two stages, so their skew is kept.
    logic [DATA_W-1:0] data_s1_q, data_s2_q;   // Data lines.
    logic [GROUPS-1:0] flag_s1_q, flag_s2_q;   // Inversion flags.
    logic              vld_s1_q, vld_s2_q;     // Valid line.
    logic [GROUPS-1:0] stbp_s1_q, stbp_s2_q;   // Positive strobes.
    logic [GROUPS-1:0] stbn_s1_q, stbn_s2_q;   // Negative strobes.
    logic [GROUPS-1:0] stbp_s3_q, stbn_s3_q;   // Previous strobe levels.

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_s1_q <= DATA_IDLE;
            data_s2_q <= DATA_IDLE;
            flag_s1_q <= GRP_IDLE;
            flag_s2_q <= GRP_IDLE;
            vld_s1_q  <= 1'b1;
            vld_s2_q  <= 1'b1;
            stbp_s1_q <= GRP_IDLE;
            stbp_s2_q <= GRP_IDLE;
            stbp_s3_q <= GRP_IDLE;
            stbn_s1_q <= GRP_IDLE;
            stbn_s2_q <= GRP_IDLE;
            stbn_s3_q <= GRP_IDLE;
        end else begin
            data_s1_q <= bus.bus_data_n;
            data_s2_q <= data_s1_q;
            flag_s1_q <= bus.group_invert_flag_n;
            flag_s2_q <= flag_s1_q;
            vld_s1_q  <= bus.transfer_valid_n;
            vld_s2_q  <= vld_s1_q;
            stbp_s1_q <= bus.group_strobe_pos_n;
            stbp_s2_q <= stbp_s1_q;
            stbp_s3_q <= stbp_s2_q;
            stbn_s1_q <= bus.group_strobe_neg_n;
            stbn_s2_q <= stbn_s1_q;
            stbn_s3_q <= stbn_s2_q;
        end
    end

    // ------------------------------------------------------------------
    // Capture and assembly
    // ------------------------------------------------------------------
    logic [GROUPS-1:0][1:0] cnt_q, cnt_d;   // Next slot per group.
    logic [GROUPS-1:0]      done_q, done_d; // Group has all four words.
    logic [BEAT_W-1:0]      asm_q, asm_d;   // Beat being assembled.
    logic                   rxv_q, rxv_d;   // Completion pulse.
    logic [BEAT_W-1:0]      rxd_q, rxd_d;   // Completed beat.
    logic                   fall;           // Strobe fall in the group.

    // Each group runs on its own strobe pair, so groups may land in
    // different cycles; the beat is released only once all have finished.
    always_comb begin
        cnt_d  = cnt_q;
        done_d = done_q;
        asm_d  = asm_q;
        rxv_d  = 1'b0;
        rxd_d  = rxd_q;
        fall   = 1'b0;
        for (int g = 0; g < GROUPS; g++) begin
            fall = (stbp_s3_q[g] && !stbp_s2_q[g])
                || (stbn_s3_q[g] && !stbn_s2_q[g]);
            if (vld_s2_q) begin
                // Released valid line: idle clock, realign slots.
                cnt_d[g] = 2'h0;
            end else if (fall) begin
                // Low line is a one; an active flag means sent inverted.
                asm_d[int'(cnt_q[g])*DATA_W + g*GROUP_W +: GROUP_W] =
                    ~data_s2_q[g*GROUP_W +: GROUP_W]
                    ^ {GROUP_W{~flag_s2_q[g]}};
                cnt_d[g] = cnt_q[g] + 2'h1;
                if (cnt_q[g] == SUB_LAST) begin
                    done_d[g] = 1'b1;
                end
            end
        end
        if (&done_d) begin
            rxv_d  = 1'b1;
            rxd_d  = asm_d;
            done_d = '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q  <= '0;
            done_q <= '0;
            asm_q  <= '0;
            rxv_q  <= 1'b0;
            rxd_q  <= '0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
            asm_q  <= asm_d;
            rxv_q  <= rxv_d;
            rxd_q  <= rxd_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rx_valid = rxv_q;
    assign rx_data  = rxd_q;

endmodule

`default_nettype wire

// ---- tb/qpdbi_monitor.sv ----
/*
 * Checker of the quad-pumped data phase as seen on the shared lines.
 * Assumes it sits beside the interface and sees its resolved levels.
 */
`timescale 1ns/100ps
`default_nettype none

module qpdbi_monitor
    import qpdbi_pkg::*;
(
    input wire logic              clk_sys,             // System clock.
    input wire logic              rst,                 // Asynchronous reset, active high.
    input wire logic              data_oe,             // Data lines driven.
    input wire logic              stb_oe,              // Strobes driven.
    input wire logic [DATA_W-1:0] bus_data_n,          // Data lines.
    input wire logic [GROUPS-1:0] group_invert_flag_n, // Inversion flags.
    input wire logic              transfer_valid_n,    // Valid marker.
    input wire logic [GROUPS-1:0] group_strobe_pos_n,  // Positive strobes.
    input wire logic [GROUPS-1:0] group_strobe_neg_n   // Negative strobes.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Strobe fall counter
    // ------------------------------------------------------------------
    logic [1:0] falls_q;  // Group 0 strobe falls, modulo four.
    logic [1:0] falls_d;  // Next count.
    logic       pos_q;    // Group 0 positive strobe one cycle back.
    logic       neg_q;    // Group 0 negative strobe one cycle back.

    // A beat carries whole quartets, so the count is zero when the valid line is released.
    always_comb begin
        falls_d = falls_q + 2'((pos_q & ~group_strobe_pos_n[0]) |
                               (neg_q & ~group_strobe_neg_n[0]));
    end

    // Idle strobe level is high, so reset loads high to avoid a false fall.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            falls_q <= 2'h0;
            pos_q   <= 1'b1;
            neg_q   <= 1'b1;
        end else begin
            falls_q <= falls_d;
            pos_q   <= group_strobe_pos_n[0];
            neg_q   <= group_strobe_neg_n[0];
        end
    end

    // ------------------------------------------------------------------
    // Sequences and assertions
    // ------------------------------------------------------------------
    sequence s_word_hold;
        ($stable(bus_data_n))[*3];
    endsequence

    sequence s_edge_hold;
        ($stable(bus_data_n) && $stable(group_invert_flag_n))[*2];
    endsequence

    sequence s_beat_valid;
        (!transfer_valid_n)[*8] ##1 (!transfer_valid_n)[*8];
    endsequence

    a_valid_with_data: assert property (data_oe |-> !transfer_valid_n)
        else $error("valid line high while data is driven");

    a_word_cadence: assert property (
        $changed(bus_data_n) && data_oe && $past(data_oe) |=> s_word_hold)
        else $error("data word held for less than a sub-phase");

    a_four_falls: assert property ($rose(transfer_valid_n) |-> falls_q == 2'h0)
        else $error("beat ended after a strobe count not a multiple of four");

    a_strobe_alternate: assert property (
        $fell(group_strobe_pos_n[0]) |->
            ##4 ($rose(group_strobe_pos_n[0]) && $fell(group_strobe_neg_n[0])))
        else $error("negative strobe did not follow positive strobe");

    a_strobe_after_valid: assert property (
        $fell(transfer_valid_n) |-> ##2 $fell(group_strobe_pos_n[0]))
        else $error("first strobe fall missing after valid");

    a_pair_opposite: assert property (
        stb_oe |-> (group_strobe_pos_n ^ group_strobe_neg_n) == GRP_IDLE)
        else $error("strobe pair not complementary");

    a_edge_hold: assert property (
        (($past(group_strobe_pos_n) & ~group_strobe_pos_n) |
         ($past(group_strobe_neg_n) & ~group_strobe_neg_n)) != 4'h0 |-> s_edge_hold)
        else $error("data or flag moved around a strobe edge");

    a_valid_span: assert property ($fell(transfer_valid_n) |-> s_beat_valid)
        else $error("valid line released inside a beat");

    // A flag may only be active where the true word had a majority of ones.
    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
        a_invert_needs_majority: assert property (
            !group_invert_flag_n[g] |->
                $countones(bus_data_n[g*GROUP_W +: GROUP_W]) > HALF_GROUP)
            else $error("group inverted without a majority of ones");
    end

endmodule

`default_nettype wire

// ---- tb/qpdbi_tb.sv ----
/*
 * Bench joining the driving and receiving ends through the shared lines.
 * Assumes the package, interface, both ends and the monitor are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module qpdbi_tb;
    import qpdbi_pkg::*;

    // ------------------------------------------------------------------
    // Table of ordinary cases
    // ------------------------------------------------------------------
    localparam int NSUB = GROUPS * SUBPHASES;
    typedef struct packed {
        logic [BEAT_W-1:0] data;  // Beat offered.
        logic              inv;   // Inversion allowed.
        logic [NSUB-1:0]   flags; // Active flags, bit sub*4+group.
    } qpdbi_row_type;
    localparam logic [BEAT_W-1:0] MIX = {64'h00FF_01FF_00FF_01FF, 64'h01FF_00FF_01FF_00FF,
                                         64'hFFFF_0000_FFFE_0001, 64'h0123_4567_89AB_CDEF};
    localparam qpdbi_row_type ROWS [5] = '{
        '{{BEAT_W{1'b0}}, 1'b1, 16'h0000},
        '{{BEAT_W{1'b1}}, 1'b1, 16'hFFFF},
        '{{BEAT_W{1'b1}}, 1'b0, 16'h0000},
        '{MIX, 1'b1, 16'h5AA1},
        '{MIX, 1'b0, 16'h0000}};

    logic              clk_sys;               // System clock.
    logic              rst;                   // Reset.
    logic              tx_valid;              // Beat offered.
    logic              inv_en;                // Inversion allowed.
    logic              tx_ready;              // Beat taken.
    logic              rx_valid;              // Beat received.
    logic              idle_seen;             // Valid seen low while idle.
    logic [BEAT_W-1:0] tx_data;               // Beat sent.
    logic [BEAT_W-1:0] rx_data;               // Beat received.
    logic [DATA_W-1:0] cap_w [SUBPHASES];     // Wire words at strobe falls.
    logic [NSUB-1:0]   cap_f;                 // Active flags at strobe falls.
    logic [NSUB-1:0]   cap_v;                 // Valid level at strobe falls.
    logic [1:0]        slot [GROUPS];         // Next slot per group.
    logic [GROUPS-1:0] prev_p;                // Positive strobes last cycle.
    logic [GROUPS-1:0] prev_n;                // Negative strobes last cycle.
    int                failures;              // Mismatches.
    int                compares;              // Comparisons.

    qpdbi_if i_qpdbi_if ();
    qpdbi_drive_end i_qpdbi_drive_end (.clk_sys(clk_sys), .rst(rst), .tx_valid(tx_valid),
        .tx_data(tx_data), .inv_en(inv_en), .tx_ready(tx_ready), .bus(i_qpdbi_if));
    qpdbi_recv_end i_qpdbi_recv_end (.clk_sys(clk_sys), .rst(rst), .bus(i_qpdbi_if),
        .rx_valid(rx_valid), .rx_data(rx_data));
    qpdbi_monitor i_qpdbi_monitor (.clk_sys(clk_sys), .rst(rst),
        .data_oe(i_qpdbi_if.data_oe), .stb_oe(i_qpdbi_if.stb_oe),
        .bus_data_n(i_qpdbi_if.bus_data_n), .group_invert_flag_n(i_qpdbi_if.group_invert_flag_n),
        .transfer_valid_n(i_qpdbi_if.transfer_valid_n),
        .group_strobe_pos_n(i_qpdbi_if.group_strobe_pos_n),
        .group_strobe_neg_n(i_qpdbi_if.group_strobe_neg_n));

    // ------------------------------------------------------------------
    // Clock, wire capture and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #(CLK_NS / 2) clk_sys = ~clk_sys;
    end

    // Each group is captured at its own strobe falls, on settled levels.
    always @(negedge clk_sys) begin
        for (int g = 0; g < GROUPS; g++) begin
            if (rst) begin
                slot[g] = 2'h0;
            end else if ((prev_p[g] && !i_qpdbi_if.group_strobe_pos_n[g]) ||
                         (prev_n[g] && !i_qpdbi_if.group_strobe_neg_n[g])) begin
                cap_w[slot[g]][g*GROUP_W +: GROUP_W] = i_qpdbi_if.bus_data_n[g*GROUP_W +: GROUP_W];
                cap_f[slot[g]*GROUPS + g] = ~i_qpdbi_if.group_invert_flag_n[g];
                cap_v[slot[g]*GROUPS + g] = i_qpdbi_if.transfer_valid_n;
                slot[g] = slot[g] + 2'h1;
            end
        end
        prev_p = i_qpdbi_if.group_strobe_pos_n;
        prev_n = i_qpdbi_if.group_strobe_neg_n;
    end

    // The tests need under two thousand cycles, so this is ample.
    initial begin
        #100000;
        failures++;
        $display("watchdog expired at %0t", $time);
        end_of_test();
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check_data(input logic [BEAT_W-1:0] got, input logic [BEAT_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bits(input logic [NSUB-1:0] got, input logic [NSUB-1:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Offers a beat and returns on the edge that takes it, valid still high.
    task automatic offer(input logic [BEAT_W-1:0] d, input logic inv);
        int n;
        n = 0;
        @(posedge clk_sys);
        #1;
        tx_data = d;
        inv_en = inv;
        tx_valid = 1'b1;
        do begin
            @(negedge clk_sys);
            n++;
        end while (tx_ready !== 1'b1 && n < 40);
        check_bits({15'h0, tx_ready}, 16'h0001);
        @(posedge clk_sys);
    endtask

    task automatic get_rx();
        int n;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (rx_valid !== 1'b1 && n < 60);
        check_bits({15'h0, rx_valid}, 16'h0001);
    endtask

    // Checks the received beat and every wire word against the table row.
    task automatic check_row(input qpdbi_row_type r);
        logic [GROUP_W-1:0] lg;
        get_rx();
        check_data(rx_data, r.data);
        check_bits(cap_f, r.flags);
        check_bits(cap_v, 16'h0000);
        for (int k = 0; k < SUBPHASES; k++) begin
            for (int g = 0; g < GROUPS; g++) begin
                lg = r.data[k*DATA_W + g*GROUP_W +: GROUP_W] ^ {GROUP_W{!r.flags[k*GROUPS+g]}};
                check_bits(cap_w[k][g*GROUP_W +: GROUP_W], lg);
            end
        end
    endtask

    task automatic check_idle();
        check_data(BEAT_W'(i_qpdbi_if.bus_data_n), BEAT_W'(DATA_IDLE));
        check_bits({3'h0, i_qpdbi_if.transfer_valid_n, i_qpdbi_if.group_invert_flag_n,
                    i_qpdbi_if.group_strobe_pos_n, i_qpdbi_if.group_strobe_neg_n}, 16'h1FFF);
        check_bits({14'h0, rx_valid, tx_ready}, 16'h0000);
        check_data(rx_data, {BEAT_W{1'b0}});
    endtask

    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        tx_valid = 1'b0;
        inv_en = 1'b0;
        tx_data = {BEAT_W{1'b0}};
        failures = 0;
        compares = 0;
        repeat (11) @(posedge clk_sys);
        @(negedge clk_sys);
        check_idle();
        @(posedge clk_sys);
        #1;
        rst = 1'b0;
        $display("test reset done");
        // Ordinary cases, one beat each with idle clocks between.
        foreach (ROWS[i]) begin
            offer(ROWS[i].data, ROWS[i].inv);
            #1;
            tx_valid = 1'b0;
            check_row(ROWS[i]);
            $display("test row %0d done", i);
        end
        // Two beats back to back keep the valid line low across the seam.
        offer(MIX, 1'b1);
        offer(~MIX, 1'b1);
        #1;
        tx_valid = 1'b0;
        get_rx();
        check_data(rx_data, MIX);
        get_rx();
        check_data(rx_data, ~MIX);
        $display("test back to back done");
        // With nothing offered the valid line must stay released.
        idle_seen = 1'b0;
        repeat (48) begin
            @(negedge clk_sys);
            idle_seen = idle_seen | !i_qpdbi_if.transfer_valid_n;
        end
        check_bits({15'h0, idle_seen}, 16'h0000);
        $display("test idle done");
        // Reset in mid-beat releases all lines, then a beat passes again.
        offer(MIX, 1'b1);
        #1;
        tx_valid = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        rst = 1'b1;
        @(negedge clk_sys);
        check_idle();
        @(posedge clk_sys);
        #1;
        rst = 1'b0;
        offer(ROWS[3].data, ROWS[3].inv);
        #1;
        tx_valid = 1'b0;
        check_row(ROWS[3]);
        $display("test mid reset done");
        end_of_test();
    end

endmodule

`default_nettype wire
